// ---- hdl/mlsp_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef MLSP_REGS_SVH
`define MLSP_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MLSP_OFF_CTRL0      8'h00
`define MLSP_OFF_CTRL1      8'h04
`define MLSP_OFF_PRESCALE   8'h08
`define MLSP_OFF_DATA       8'h0C
`define MLSP_OFF_STATUS     8'h10
`define MLSP_OFF_INT_STATUS 8'h14
`define MLSP_OFF_INT_MASK   8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MLSP_C0_MODE_LSB    0
`define MLSP_C0_SRD_LSB     8
`define MLSP_C1_ENABLE      0
`define MLSP_C1_MASTER      1
`define MLSP_C1_DIR_RX      2
`define MLSP_C1_CLK_DRIVE   3
`define MLSP_ST_BUSY        0
`define MLSP_ST_RX_VALID    1
`define MLSP_ST_RELEASED    2
`define MLSP_IRQ_DONE       0
`define MLSP_IRQ_TIMEOUT    1

// ----------------------------------------------------------------------
// Lane mode codes, reset values, timing
// ----------------------------------------------------------------------
`define MLSP_MODE_LEGACY    2'h0
`define MLSP_MODE_DUAL      2'h1
`define MLSP_MODE_QUAD      2'h2
`define MLSP_PRESCALE_RST   8'h02
`define MLSP_PRESCALE_MIN   8'h02
`define MLSP_SRD_RST        8'h00
`define MLSP_CTRL1_RST      4'h0
`define MLSP_FRAME_BITS     8
`define MLSP_RX_TMO_CYC     32

`endif

// ---- hdl/mlsp_pkg.sv ----
// Types and shared decode helpers for the multi-lane serial port
package mlsp_pkg;
  `include "mlsp_regs.svh"

  typedef enum logic {MLSP_IDLE, MLSP_SHIFT} mlsp_state_t;

  // Rising serial clock edges in one frame for a lane mode
  function automatic logic [3:0] mlsp_frame_clks(input logic [1:0] mode);
    unique case (mode)
      `MLSP_MODE_DUAL: mlsp_frame_clks = 4'h4;
      `MLSP_MODE_QUAD: mlsp_frame_clks = 4'h2;
      default:         mlsp_frame_clks = 4'h8;
    endcase
  endfunction

  // True when the mode uses the data lanes both ways
  function automatic logic mlsp_multi(input logic [1:0] mode);
    mlsp_multi = (mode == `MLSP_MODE_DUAL) || (mode == `MLSP_MODE_QUAD);
  endfunction
endpackage

// ---- hdl/mlsp_clkgen.sv ----
// Serial clock half-period tick generator from prescale and divider
`timescale 1ns/10ps
`include "mlsp_regs.svh"
module mlsp_clkgen
  import mlsp_pkg::*;
#(
  parameter int PW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire logic          run,
  input  wire logic [PW-1:0] prescale,
  input  wire logic [DW-1:0] divider,
  // Half-period strobe
  output logic               tick
);

  logic [PW-1:0]    psc_eff;
  logic [PW+DW-1:0] half_w;
  logic [PW+DW-1:0] cnt_r;

  // Odd or too small prescale is rounded to a legal even value
  always_comb begin
    psc_eff = (prescale < `MLSP_PRESCALE_MIN) ? `MLSP_PRESCALE_MIN
                                              : {prescale[PW-1:1], 1'b0};
    half_w  = {{(DW+1){1'b0}}, psc_eff[PW-1:1]} *
              ({{PW{1'b0}}, divider} + 1'b1); // RULE6
  end

  // Count half periods; idle restarts so the first edge is a full half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= half_w - 1'b1) begin
      cnt_r <= '0;
      tick  <= 1'b1; // RULE6
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// ---- hdl/mlsp_top.sv ----
// Multi-lane serial port: APB registers, lane control, rx timeout
//
// Contract
// RULE1: Direction bit in dual/quad makes lanes receive
// RULE2: Release lane drivers before first read clock
// RULE3: Software does one dummy read first
// RULE4: Every read, dummy included, emits serial clocks
// RULE5: Software may park clock pin during dummy
// RULE6: Clock equals system clock over prescale*(1+divider); odd prescale is rounded down to even, minimum 2
// RULE7: Receive timeout fires after exactly 32 clocks
// RULE8: Master timeout independent of prescale value
// RULE9: Slave timeout users keep prescale at two
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "mlsp_regs.svh"
module mlsp_top
  import mlsp_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock pin
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  // Data lanes
  input  wire logic [3:0]  dat_i,
  output logic [3:0]       dat_o,
  output logic [3:0]       dat_oe,
  // Interrupt
  output logic             irq
);

  // --------------------------------------------------------------------
  // Registers and internal signals
  // --------------------------------------------------------------------
  logic [1:0]  mode_r;
  logic [7:0]  serial_rate_divider_r;
  logic [3:0]  port_control_one_r;
  logic [7:0]  clock_prescale_value_r;
  logic [7:0]  tx_hold_r, tx_sh_r, rx_sh_r, rx_data_r;
  logic        rx_valid_r;
  logic [1:0]  istat_r, imask_r;
  logic [3:0]  rises_r;
  logic [5:0]  tmo_cnt_r;
  logic        sclk_in_q_r;
  mlsp_state_t state_r;
  logic        en, master, dir_rx, multi, tick;
  logic        setup, acc, acc_wr, acc_rd;
  logic        start_m, sample_ev, shift_ev, done_ev, tmo_ev;
  logic [7:0]  rx_shift_nxt;
  logic [31:0] rd_nxt;
  logic        unmapped;

  assign en     = port_control_one_r[`MLSP_C1_ENABLE];
  assign master = port_control_one_r[`MLSP_C1_MASTER];
  assign dir_rx = port_control_one_r[`MLSP_C1_DIR_RX];
  assign multi  = mlsp_multi(mode_r);

  // --------------------------------------------------------------------
  // APB decode; one wait-free access phase, pready from a flop
  // --------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign acc    = psel && penable && pready;
  assign acc_wr = acc && pwrite;
  assign acc_rd = acc && !pwrite;

  always_comb begin
    rd_nxt   = 32'h0000_0000;
    unmapped = 1'b0;
    unique case (paddr)
      `MLSP_OFF_CTRL0:      rd_nxt = {16'h0000, serial_rate_divider_r,
                                      6'h00, mode_r};
      `MLSP_OFF_CTRL1:      rd_nxt = {28'h0000000, port_control_one_r};
      `MLSP_OFF_PRESCALE:   rd_nxt = {24'h000000, clock_prescale_value_r};
      `MLSP_OFF_DATA:       rd_nxt = {24'h000000, rx_data_r};
      `MLSP_OFF_STATUS:     rd_nxt = {29'h00000000, dat_oe == 4'h0,
                                      rx_valid_r, state_r == MLSP_SHIFT};
      `MLSP_OFF_INT_STATUS: rd_nxt = {30'h00000000, istat_r};
      `MLSP_OFF_INT_MASK:   rd_nxt = {30'h00000000, imask_r};
      default:              unmapped = 1'b1;
    endcase
  end

  // Bus answer: data, ready and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && unmapped;
      prdata  <= (setup && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r                 <= `MLSP_MODE_LEGACY;
      serial_rate_divider_r  <= `MLSP_SRD_RST;
      port_control_one_r     <= `MLSP_CTRL1_RST;
      clock_prescale_value_r <= `MLSP_PRESCALE_RST;
      imask_r                <= 2'h0;
      tx_hold_r              <= 8'h00;
    end else if (acc_wr) begin
      unique case (paddr)
        `MLSP_OFF_CTRL0: begin
          mode_r                <= pwdata[`MLSP_C0_MODE_LSB +: 2];
          serial_rate_divider_r <= pwdata[`MLSP_C0_SRD_LSB +: 8];
        end
        `MLSP_OFF_CTRL1:     port_control_one_r     <= pwdata[3:0];
        `MLSP_OFF_PRESCALE:  clock_prescale_value_r <= pwdata[7:0];
        `MLSP_OFF_INT_MASK:  imask_r                <= pwdata[1:0];
        `MLSP_OFF_DATA:      tx_hold_r              <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Serial clock generation and edge events
  // --------------------------------------------------------------------
  mlsp_clkgen #(.PW(8), .DW(8)) i_mlsp_clkgen (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (state_r == MLSP_SHIFT && master),
    .prescale (clock_prescale_value_r),
    .divider  (serial_rate_divider_r),
    .tick     (tick)
  );

  // Master start is refused, not deferred, while lanes are still driven in receive
  // mode, so the first read clock never meets our own drivers
  assign start_m = acc_wr && paddr == `MLSP_OFF_DATA && en && master &&
                   state_r == MLSP_IDLE &&
                   !(multi && dir_rx && dat_oe != 4'h0); // RULE2

  // Any accepted master data write, dummy or real, runs a full clocked frame
  assign sample_ev = master ? (tick && state_r == MLSP_SHIFT && !sclk_o)
                            : (en && sclk_i && !sclk_in_q_r); // RULE4
  assign shift_ev  = master ? (tick && state_r == MLSP_SHIFT && sclk_o)
                            : (en && !sclk_i && sclk_in_q_r);
  assign done_ev   = shift_ev && state_r == MLSP_SHIFT && rises_r == 4'h0;

  // Sample lanes: legacy takes one line, dual two, quad four
  always_comb begin
    unique case (mode_r)
      `MLSP_MODE_DUAL: rx_shift_nxt = {rx_sh_r[5:0], dat_i[1:0]};
      `MLSP_MODE_QUAD: rx_shift_nxt = {rx_sh_r[3:0], dat_i[3:0]};
      default:         rx_shift_nxt = {rx_sh_r[6:0],
                                       master ? dat_i[1] : dat_i[0]};
    endcase
  end

  // Frame sequencer: sample on rise, shift or finish on fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MLSP_IDLE;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rises_r <= 4'h0;
    end else if (!en) begin
      state_r <= MLSP_IDLE;
    end else if (start_m) begin
      state_r <= MLSP_SHIFT;
      tx_sh_r <= pwdata[7:0];
      rises_r <= mlsp_frame_clks(mode_r);
    end else if (sample_ev) begin
      state_r <= MLSP_SHIFT;
      rx_sh_r <= rx_shift_nxt;
      rises_r <= (state_r == MLSP_IDLE) ? mlsp_frame_clks(mode_r) - 4'h1
                                        : rises_r - 4'h1;
    end else if (done_ev) begin
      state_r <= MLSP_IDLE;
    end else if (shift_ev && state_r == MLSP_SHIFT) begin
      tx_sh_r <= tx_sh_r << (4'h8 / mlsp_frame_clks(mode_r));
    end else if (state_r == MLSP_IDLE && !master) begin
      tx_sh_r <= tx_hold_r;
    end
  end

  // Serial clock pin; the drive bit lets software park the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_o      <= 1'b0;
      sclk_oe     <= 1'b0;
      sclk_in_q_r <= 1'b0;
    end else begin
      sclk_in_q_r <= sclk_i;
      sclk_oe     <= en && master &&
                     port_control_one_r[`MLSP_C1_CLK_DRIVE]; // RULE5
      if (!master || state_r == MLSP_IDLE)
        sclk_o <= 1'b0;
      else if (tick)
        sclk_o <= !sclk_o; // RULE6
    end
  end

  // Lane drivers: receive direction in dual/quad drops every enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_o  <= 4'h0;
      dat_oe <= 4'h0;
    end else begin
      unique case (mode_r)
        `MLSP_MODE_DUAL: begin
          dat_o  <= {2'h0, tx_sh_r[7:6]};
          dat_oe <= (en && !dir_rx) ? 4'h3 : 4'h0; // RULE1
        end
        `MLSP_MODE_QUAD: begin
          dat_o  <= tx_sh_r[7:4];
          dat_oe <= (en && !dir_rx) ? 4'hF : 4'h0; // RULE1
        end
        default: begin
          dat_o  <= master ? {3'h0, tx_sh_r[7]} : {2'h0, tx_sh_r[7], 1'b0};
          dat_oe <= !en ? 4'h0 : (master ? 4'h1 : 4'h2);
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Receive holding word and timeout
  // --------------------------------------------------------------------
  // New data wins over a read that clears the valid flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r  <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (done_ev) begin
      rx_data_r  <= rx_sh_r;
      rx_valid_r <= 1'b1;
    end else if (acc_rd && paddr == `MLSP_OFF_DATA) begin
      rx_valid_r <= 1'b0;
    end
  end

  // Counts system clocks only, so prescale and mode cannot shorten it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tmo_cnt_r <= 6'h00;
    else if (!rx_valid_r || done_ev)
      tmo_cnt_r <= 6'h00; // RULE8
    else if (tmo_cnt_r != 6'(`MLSP_RX_TMO_CYC))
      tmo_cnt_r <= tmo_cnt_r + 6'h01; // RULE7
  end

  assign tmo_ev = rx_valid_r && !done_ev &&
                  tmo_cnt_r == 6'(`MLSP_RX_TMO_CYC - 1); // RULE7

  // --------------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 2'h0;
    end else begin
      istat_r[`MLSP_IRQ_DONE] <= done_ev || (istat_r[`MLSP_IRQ_DONE] &&
        !(acc_wr && paddr == `MLSP_OFF_INT_STATUS &&
          pwdata[`MLSP_IRQ_DONE]));
      istat_r[`MLSP_IRQ_TIMEOUT] <= tmo_ev || (istat_r[`MLSP_IRQ_TIMEOUT] &&
        !(acc_wr && paddr == `MLSP_OFF_INT_STATUS &&
          pwdata[`MLSP_IRQ_TIMEOUT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(istat_r & imask_r);
  end

  // --------------------------------------------------------------------
  // Assertions and helpers
  // --------------------------------------------------------------------
  logic [3:0]  rise_seen;
  logic [16:0] per_cnt, per_exp;
  logic [7:0]  psc_chk;
  always_comb begin
    psc_chk = (clock_prescale_value_r < `MLSP_PRESCALE_MIN) ?
              `MLSP_PRESCALE_MIN : {clock_prescale_value_r[7:1], 1'b0};
    per_exp = {9'h000, psc_chk} * ({9'h000, serial_rate_divider_r} + 17'h1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_seen <= 4'h0;
      per_cnt   <= 17'h0;
    end else begin
      if (start_m) rise_seen <= 4'h0;
      else if (sclk_o == 1'b0 && sample_ev) rise_seen <= rise_seen + 4'h1;
      per_cnt <= (state_r == MLSP_IDLE || (sample_ev && master)) ? 17'h1
                 : per_cnt + 17'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dir_release: assert property (en && dir_rx && multi |=> dat_oe == 4'h0) // RULE1
    else $error("lanes still driven in receive mode");
  a_no_contention: assert property ($rose(sclk_o) && dir_rx && multi
    |-> dat_oe == 4'h0) // RULE2
    else $error("read clock while lanes driven");
  a_read_clocks: assert property (done_ev && master
    |-> rise_seen == mlsp_frame_clks(mode_r)) // RULE4
    else $error("frame without full serial clocks");
  // A one-cycle half period toggles every edge, so only the rise is held
  a_clk_period: assert property (sample_ev && master |=> sclk_o) // RULE6
    else $error("serial clock did not rise on a sample tick");
  a_rate_exact: assert property (master && sample_ev && rise_seen != 4'h0
    |-> per_cnt == per_exp) // RULE6
    else $error("serial clock period differs from prescale times divider");
  a_tmo_slave: assert property (!master && tmo_ev
    |-> $past(rx_valid_r, 31) && tmo_cnt_r == 6'h1F) // RULE7
    else $error("slave timeout before 32 clocks");
  a_tmo_no_early: assert property ($rose(rx_valid_r) |-> (!tmo_ev) [*8]) // RULE7
    else $error("timeout right after data arrived");
  a_tmo_master: assert property (master && tmo_ev
    |-> $past(rx_valid_r, 31)) // RULE8
    else $error("master timeout shortened");
  a_sticky_clear: assert property ($fell(istat_r[`MLSP_IRQ_TIMEOUT])
    |-> $past(acc_wr) && $past(paddr) == `MLSP_OFF_INT_STATUS)
    else $error("timeout status lost without write one");

  c_dummy_read: cover property (start_m && dir_rx && multi ##[1:1000] done_ev);
  c_timeout:    cover property (tmo_ev);
  c_slave_rx:   cover property (!master && done_ev);
  c_irq:        cover property ($rose(irq));

endmodule

// ---- tb/mlsp_mem_model.sv ----
// Behavioural serial memory or peer on the far side of the data lanes
`timescale 1ns/10ps
module mlsp_mem_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control
  input  wire logic       drive,
  input  wire logic       load,
  input  wire logic       slave,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] byte_out,
  // Serial clock pin
  input  wire logic       sclk_i,
  input  wire logic       sclk_o,
  input  wire logic       sclk_oe,
  // Data lanes
  input  wire logic [3:0] dat_o,
  input  wire logic [3:0] dat_oe,
  output logic [3:0]      dat_i,
  output logic            contention
);
  logic       sck;
  logic [3:0] falls;
  logic [7:0] sh;
  logic [3:0] mem_dat;
  logic [3:0] mem_oe;
  logic [3:0] pat_r;

  // The pin level is whoever drives it; the bench holds sclk_i otherwise
  assign sck = sclk_oe ? sclk_o : sclk_i;

  // Shift on falling edges so data is settled before the next rise
  always @(negedge sck or posedge load) begin
    if (load)
      falls <= 4'h0;
    else
      falls <= falls + 4'h1;
  end

  // Undriven lanes wander every cycle so a stale value never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pat_r <= 4'h5;
    else
      pat_r <= pat_r + 4'h3;
  end

  // Present the byte MSB first on the lanes the mode uses
  always_comb begin
    sh = byte_out << (falls * (mode == 2'h2 ? 4 : mode == 2'h1 ? 2 : 1));
    mem_dat = 4'h0;
    mem_oe = 4'h0;
    if (mode == 2'h2) begin
      mem_dat = sh[7:4];
      mem_oe = 4'hF;
    end else if (mode == 2'h1) begin
      mem_dat = {2'h0, sh[7:6]};
      mem_oe = 4'h3;
    end else begin
      mem_dat = slave ? {3'h0, sh[7]} : {2'h0, sh[7], 1'h0};
      mem_oe = slave ? 4'h1 : 4'h2;
    end
    if (!drive)
      mem_oe = 4'h0;
  end

  // Resolve each lane from both parties' enables
  assign dat_i = (dat_oe & dat_o) | (~dat_oe & mem_oe & mem_dat)
               | (~dat_oe & ~mem_oe & pat_r);
  assign contention = |(dat_oe & mem_oe);
endmodule

// ---- tb/test_multi_lane_serial_port_rx_timing.sv ----
// Self-checking bench for the multi-lane serial port receive timing
`timescale 1ns/10ps
`include "mlsp_regs.svh"
module test_multi_lane_serial_port_rx_timing;
  import mlsp_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sclk_i = 0, drive = 0, load = 0, slave = 0, sprev = 0;
  logic [7:0]  paddr = 8'h00, mem_byte = 8'h00, txb = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sclk_o, sclk_oe, irq, contention;
  logic [3:0]  dat_i, dat_o, dat_oe;
  logic [1:0]  mode = 2'h0;
  int          errors = 0, samples_checked = 0, cyc = 0;
  int          rises = 0, t1 = 0, t2 = 0, conts = 0;
  integer      seed = 32'h94bfcf00;
  logic [7:0]  want_q[$];

  // ----------------------------------------------------------------------
  // Clock, instances and monitors
  // ----------------------------------------------------------------------
  initial forever #4 pclk = ~pclk;

  mlsp_top i_mlsp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .dat_i(dat_i), .dat_o(dat_o),
    .dat_oe(dat_oe), .irq(irq));

  mlsp_mem_model i_mlsp_mem_model (.pclk(pclk), .presetn(presetn),
    .drive(drive), .load(load), .slave(slave), .mode(mode),
    .byte_out(mem_byte), .sclk_i(sclk_i), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .dat_o(dat_o), .dat_oe(dat_oe), .dat_i(dat_i),
    .contention(contention));

  // Count serial clock rises, time the first two, and count contention
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sprev <= sclk_o;
    if (contention === 1'b1)
      conts <= conts + 1;
    if (sclk_o === 1'b1 && sprev === 1'b0) begin
      rises <= rises + 1;
      txb <= {txb[6:0], dat_o[0]};
      if (rises == 0)
        t1 <= cyc;
      if (rises == 1)
        t2 <= cyc;
    end
  end

  // ----------------------------------------------------------------------
  // Compare, bus and sequence tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_cnt(input int got, input int want);
    chk_val(32'(got), 32'(want));
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] want);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    chk_val(rd & m, want);
  endtask

  // Wait for a rising irq; a bound keeps a dead design from hanging
  task automatic wait_irq(output int t);
    int   n;
    logic prev;
    prev = irq;
    n = 0;
    forever begin
      @(posedge pclk);
      n++;
      if (irq === 1'b1 && prev === 1'b0)
        break;
      if (n > 5000) begin
        errors++;
        summarize();
      end
      prev = irq;
    end
    t = cyc;
  endtask

  // Disable first so a lane mode change never meets driven lanes
  task automatic cfg(input logic [1:0] m, input logic [3:0] c1,
                     input logic [7:0] p, input logic [7:0] dv);
    drive <= 1'b0;
    mode <= m;
    slave <= ~c1[1];
    wr(`MLSP_OFF_CTRL1, 32'h0);
    wr(`MLSP_OFF_CTRL0, {16'h0, dv, 6'h0, m});
    wr(`MLSP_OFF_PRESCALE, {24'h0, p});
    wr(`MLSP_OFF_CTRL1, {28'h0, c1});
    repeat (2) @(posedge pclk);
  endtask

  task automatic frame(input logic slv, input logic keep, output int t);
    mem_byte <= 8'($random(seed));
    load <= 1'b1;
    drive <= 1'b1;
    rises = 0;
    conts = 0;
    @(posedge pclk);
    load <= 1'b0;
    if (slv) begin
      repeat (8) begin
        repeat (4) @(posedge pclk);
        sclk_i <= 1'b1;
        repeat (4) @(posedge pclk);
        sclk_i <= 1'b0;
      end
    end else begin
      wr(`MLSP_OFF_DATA, 32'h5A);
    end
    wait_irq(t);
    if (keep)
      want_q.push_back(mem_byte);
  endtask

  task automatic drain(input logic keep);
    logic [31:0] rd;
    logic        e;
    wr(`MLSP_OFF_INT_STATUS, 32'h1);
    apb(1'b0, `MLSP_OFF_DATA, 32'h0, rd, e);
    if (keep)
      chk_val(rd, {24'h0, want_q.pop_front()});
  endtask

  // Unread byte must raise the timeout exactly 32 cycles after done
  task automatic tmo(input logic slv, input logic [7:0] p);
    int a, b;
    cfg(`MLSP_MODE_LEGACY, slv ? 4'h1 : 4'hB, p, 8'h00);
    frame(slv, 1'b1, a);
    wr(`MLSP_OFF_INT_MASK, 32'h2);
    wait_irq(b);
    chk_cnt(b - a, `MLSP_RX_TMO_CYC);
    rdc(`MLSP_OFF_INT_STATUS, 32'h3, 32'h3);
    wr(`MLSP_OFF_INT_STATUS, 32'h3);
    rdc(`MLSP_OFF_INT_STATUS, 32'h3, 32'h0);
    chk_val({31'h0, irq}, 32'h0);
    wr(`MLSP_OFF_INT_MASK, 32'h1);
    drain(1'b1);
    $display("timeout test slave=%0d prescale=%0d done", slv, p);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int t0, pr, dv;
    logic [31:0] rd;
    logic        e;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`MLSP_OFF_PRESCALE, 32'hFF, 32'h02);
    rdc(`MLSP_OFF_CTRL0, 32'hFFFF, 32'h0);
    rdc(`MLSP_OFF_CTRL1, 32'hF, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, rd, e);
    chk_val({31'h0, e}, 32'h1);
    chk_val(rd, 32'h0);
    wr(`MLSP_OFF_INT_MASK, 32'h1);
    $display("reset and map test done");
    // Each lane mode: two reads, both checked, random clock settings
    for (int m = 0; m < 3; m++) begin
      pr = 2 * (1 + ($random(seed) & 7));
      dv = $random(seed) & 3;
      cfg(m[1:0], (m != 0) ? 4'hF : 4'hB, pr[7:0], dv[7:0]);
      if (m != 0) begin
        chk_val({28'h0, dat_oe}, 32'h0);
        rdc(`MLSP_OFF_STATUS, 32'h4, 32'h4);
      end
      repeat (2) begin
        frame(1'b0, 1'b1, t0);
        chk_cnt(rises, 8 >> m);
        chk_cnt(t2 - t1, pr * (1 + dv));
        chk_cnt(conts, 0);
        if (m == 0) chk_val({24'h0, txb}, 32'h5A);
        drain(1'b1);
      end
      $display("lane test mode=%0d done", m);
    end
    // Dummy read with the clock pin parked as an input
    cfg(`MLSP_MODE_DUAL, 4'h7, 8'h02, 8'h00);
    chk_val({31'h0, sclk_oe}, 32'h0);
    frame(1'b0, 1'b0, t0);
    drain(1'b0);
    cfg(`MLSP_MODE_DUAL, 4'hF, 8'h02, 8'h00);
    chk_val({31'h0, sclk_oe}, 32'h1);
    $display("parked clock test done");
    tmo(1'b0, 8'h02);
    tmo(1'b0, 8'hFE);
    tmo(1'b1, 8'h02);
    summarize();
  end
endmodule
